// *** src/aio_pkg.sv ***
// package for the per-axis motion i/o status and interrupt block
// assumes an ahb-lite slave with 32-bit data and four axes
package aio_pkg;

    localparam int NUM_AXES = 4;

    // ------------------------------------------------------------
    // register map, one aligned word each; axis block stride 0x20
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CARD_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CARD_PEND = 8'h04;
    localparam logic [7:0] AXIS_BASE = 8'h20;
    localparam logic [4:0] AXIS_STRIDE_SHIFT = 5'h05;
    localparam logic [2:0] AX_IO_STATUS = 3'h0;
    localparam logic [2:0] AX_FACTOR_MASK = 3'h1;
    localparam logic [2:0] AX_FAULT_CAUSE = 3'h2;
    localparam logic [2:0] AX_EVENT_CAUSE = 3'h3;
    localparam logic [2:0] AX_IRQ_TYPE = 3'h4;
    localparam logic [2:0] AX_STOP_CTRL = 3'h5;
    localparam logic [2:0] AX_POLARITY = 3'h6;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_STOP_ENABLE = 0;
    localparam int BIT_STOP_MASK = 1;
    localparam int BIT_AXIS_STOP = 31;
    localparam logic [15:0] IO_VALID_MASK = 16'h7bff;
    localparam logic [31:0] EVENT_VALID_MASK = 32'h8009d8f7;
    localparam logic [31:0] FACTOR_VALID_MASK = 32'h0009dff7;
    localparam logic [31:0] FAULT_VALID_MASK = 32'h0003f7eb;
    localparam logic [31:0] RST_FACTOR_MASK = 32'h00000000;
    localparam logic [15:0] RST_POLARITY = 16'h0000;
    localparam logic [1:0] IRQ_TYPE_NONE = 2'h0;
    localparam logic [1:0] IRQ_TYPE_FAULT = 2'h1;
    localparam logic [1:0] IRQ_TYPE_EVENT = 2'h2;
    localparam logic [1:0] IRQ_TYPE_BOTH = 2'h3;

    // raw motion i/o levels of one axis, same bit order as the status word
    typedef struct packed {
        logic servo_on_out;
        logic in_position_in;
        logic slow_down_in;
        logic latch_in;
        logic reserved_10;
        logic encoder_index;
        logic error_clear_out;
        logic position_change_in;
        logic emergency_in;
        logic direction_out;
        logic origin_switch;
        logic negative_end_limit;
        logic positive_end_limit;
        logic alarm_in;
        logic driver_ready;
    } aio_pins_type;

    // cause pulses reported by the motion logic of one axis
    typedef struct packed {
        logic [31:0] fault;
        logic [31:0] event_hit;
        logic cmd_start;
        logic axis_stopped;
    } aio_cause_type;

endpackage

// *** src/aio_axis_io_status_and_irq.sv ***
// per-axis motion i/o status monitor and interrupt cause logic
// assumes an ahb-lite master, one slave on the bus, cause pulses from motion logic
//
// Notes on behaviour
// - status bits 0-9 live i/o, bit 10 reserved
// - status bits 11-14 latch, slowdown, inpos, servo
// - status bit is 1 when signal logically on
// - card-wide enable gates host interrupt
// - two 32-bit cause words per axis
// - event cause interrupts only if mask bit set, except bit 31
// - fault causes unmaskable once card enabled
// - event bits 0-2 and 4-7 stop and ramp events
// - event bits 11,12,14,15,16,19,31 used, rest reserved
// - mask word also takes bits 8-10
// - fault bits 0,1,3,5-10 stop reasons
// - fault bits 12-17 interpolation and input errors
// - reading causes returns word then clears it
// - irq type 1 fault, 2 event, 3 both
// - pending flag shows card drives host irq
// - axis stop sets event bit 31 when enabled
// - axis stop enable separate from mask word
// - per-command mask 0 active, 1 inactive
`timescale 1ns/100ps
`default_nettype none

module aio_axis_io_status_and_irq
    import aio_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire aio_pins_type [NUM_AXES-1:0] i_pins,
    input wire aio_cause_type [NUM_AXES-1:0] i_cause,
    output logic o_host_irq
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    wire logic rst_n = rst_sync_ff;

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    logic dp_valid_ff;
    logic dp_write_ff;
    logic [7:0] dp_addr_ff;
    logic [31:0] rdata_ff;

    wire logic addr_take = i_hsel && i_htrans[1] && i_hready;
    wire logic wr_do = dp_valid_ff && dp_write_ff;

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_valid_ff <= 1'b0;
            dp_write_ff <= 1'b0;
            dp_addr_ff <= 8'h00;
        end else begin
            dp_valid_ff <= addr_take;
            dp_write_ff <= addr_take && i_hwrite;
            dp_addr_ff <= addr_take ? i_haddr[7:0] : dp_addr_ff;
        end
    end

    // zero-wait slave, every access answered okay
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = rdata_ff;

    // address of an axis block; returns index NUM_AXES when not an axis
    function automatic logic [2:0] axis_of(input logic [7:0] a);
        logic [2:0] idx;
        idx = 3'(NUM_AXES);
        if (a >= AXIS_BASE && a < AXIS_BASE + 8'(NUM_AXES << AXIS_STRIDE_SHIFT)) begin
            idx = 3'((a - AXIS_BASE) >> AXIS_STRIDE_SHIFT);
        end
        return idx;
    endfunction

    function automatic logic [2:0] reg_of(input logic [7:0] a);
        return a[4:2];
    endfunction

    wire logic [2:0] rd_axis = axis_of(i_haddr[7:0]);
    wire logic [2:0] rd_reg = reg_of(i_haddr[7:0]);
    wire logic [2:0] wr_axis = axis_of(dp_addr_ff);
    wire logic [2:0] wr_reg = reg_of(dp_addr_ff);
    wire logic rd_take = addr_take && !i_hwrite;

    // ------------------------------------------------------------
    // card-wide control
    // ------------------------------------------------------------
    logic card_irq_enable_ff;

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            card_irq_enable_ff <= 1'b0;
        end else if (wr_do && dp_addr_ff == ADDR_CARD_CTRL) begin
            card_irq_enable_ff <= i_hwdata[0];
        end
    end

    // ------------------------------------------------------------
    // per-axis registers and causes
    // ------------------------------------------------------------
    logic [31:0] factor_mask_ff [NUM_AXES];
    logic [15:0] polarity_ff [NUM_AXES];
    logic stop_enable_ff [NUM_AXES];
    logic stop_cmd_mask_ff [NUM_AXES];
    logic stop_cmd_active_ff [NUM_AXES];
    logic [31:0] fault_cause_ff [NUM_AXES];
    logic [31:0] event_cause_ff [NUM_AXES];
    logic [15:0] io_status [NUM_AXES];
    logic [1:0] irq_type [NUM_AXES];
    logic [NUM_AXES-1:0] axis_req;

    for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
        wire logic sel_wr = wr_do && wr_axis == 3'(g);
        wire logic clr_rd = rd_take && rd_axis == 3'(g);
        // logical on = raw level equal to the configured active level
        wire logic [15:0] raw_io = {1'b0, i_pins[g]};
        wire logic [31:0] stop_evt;
        wire logic fault_any = |fault_cause_ff[g];
        // the axis-stop bit is already gated by its own enable, so the factor mask skips it
        wire logic event_any = |(event_cause_ff[g]
                                 & (factor_mask_ff[g] | (32'h1 << BIT_AXIS_STOP)));

        assign io_status[g] = ~(raw_io ^ polarity_ff[g]) & IO_VALID_MASK;
        // stop report gated by the enable and the mask of the running command
        assign stop_evt = {stop_enable_ff[g] && stop_cmd_active_ff[g]
                           && i_cause[g].axis_stopped, 31'h0};
        assign axis_req[g] = fault_any || event_any;
        assign irq_type[g] = {event_any, fault_any};

        always_ff @(posedge i_sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                factor_mask_ff[g] <= RST_FACTOR_MASK;
                polarity_ff[g] <= RST_POLARITY;
                stop_enable_ff[g] <= 1'b0;
                stop_cmd_mask_ff[g] <= 1'b0;
                stop_cmd_active_ff[g] <= 1'b0;
            end else begin
                if (sel_wr && wr_reg == AX_FACTOR_MASK) begin
                    factor_mask_ff[g] <= i_hwdata & FACTOR_VALID_MASK;
                end
                if (sel_wr && wr_reg == AX_POLARITY) begin
                    polarity_ff[g] <= i_hwdata[15:0];
                end
                if (sel_wr && wr_reg == AX_STOP_CTRL) begin
                    stop_enable_ff[g] <= i_hwdata[BIT_STOP_ENABLE];
                    stop_cmd_mask_ff[g] <= i_hwdata[BIT_STOP_MASK];
                end
                // the mask is sampled as each motion command starts
                if (i_cause[g].cmd_start) begin
                    stop_cmd_active_ff[g] <= !stop_cmd_mask_ff[g];
                end
            end
        end

        // new causes win over the clear of the read that sees the old word
        always_ff @(posedge i_sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                fault_cause_ff[g] <= 32'h00000000;
                event_cause_ff[g] <= 32'h00000000;
            end else begin
                fault_cause_ff[g] <= ((clr_rd && rd_reg == AX_FAULT_CAUSE)
                                      ? 32'h0 : fault_cause_ff[g])
                                     | (i_cause[g].fault & FAULT_VALID_MASK);
                event_cause_ff[g] <= ((clr_rd && rd_reg == AX_EVENT_CAUSE)
                                      ? 32'h0 : event_cause_ff[g])
                                     | (i_cause[g].event_hit & EVENT_VALID_MASK
                                        & ~(32'h1 << BIT_AXIS_STOP))
                                     | stop_evt;
            end
        end
    end

    // ------------------------------------------------------------
    // host interrupt and read data
    // ------------------------------------------------------------
    logic host_irq_ff;

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_irq_ff <= 1'b0;
        end else begin
            // request falls once the host has read away every unmasked cause
            host_irq_ff <= card_irq_enable_ff && (|axis_req);
        end
    end

    assign o_host_irq = host_irq_ff;

    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h00000000;
        if (rd_axis < 3'(NUM_AXES)) begin
            unique case (rd_reg)
                AX_IO_STATUS: rd_mux = {16'h0, io_status[rd_axis[1:0]]};
                AX_FACTOR_MASK: rd_mux = factor_mask_ff[rd_axis[1:0]];
                AX_FAULT_CAUSE: rd_mux = fault_cause_ff[rd_axis[1:0]];
                AX_EVENT_CAUSE: rd_mux = event_cause_ff[rd_axis[1:0]];
                AX_IRQ_TYPE: rd_mux = {30'h0, irq_type[rd_axis[1:0]]};
                AX_STOP_CTRL: rd_mux = {30'h0, stop_cmd_mask_ff[rd_axis[1:0]],
                                        stop_enable_ff[rd_axis[1:0]]};
                AX_POLARITY: rd_mux = {16'h0, polarity_ff[rd_axis[1:0]]};
                default: rd_mux = 32'h00000000;
            endcase
        end else if (i_haddr[7:0] == ADDR_CARD_CTRL) begin
            rd_mux = {31'h0, card_irq_enable_ff};
        end else if (i_haddr[7:0] == ADDR_CARD_PEND) begin
            rd_mux = {31'h0, host_irq_ff};
        end
    end

    // read data is captured at the address phase so the clear cannot corrupt it
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h00000000;
        end else if (rd_take) begin
            rdata_ff <= rd_mux;
        end
    end

endmodule
`default_nettype wire

// *** dv/aio_axis_io_status_and_irq_assertions.sv ***
// checker for the status and interrupt block, bound to its top module
// assumes one zero-wait ahb-lite slave and cause pulses held one cycle
`timescale 1ns/100ps
`default_nettype none
module aio_irq_checker
    import aio_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire aio_pins_type [NUM_AXES-1:0] i_pins,
    input wire aio_cause_type [NUM_AXES-1:0] i_cause,
    input wire logic o_host_irq
);
    wire aph = i_hsel & i_htrans[1] & i_hready;
    wire rd_aph = aph & !i_hwrite;
    wire ax_rd = rd_aph & (i_haddr[7:5] != 3'h0) & (i_haddr[7:5] <= 3'h4);
    wire [2:0] reg_sel = i_haddr[4:2];
    logic wr_ctrl_ff;
    logic en_ff;
    logic fault_hit;
    always_comb begin
        fault_hit = 1'b0;
        for (int n = 0; n < NUM_AXES; n++) begin
            fault_hit = fault_hit | (|(i_cause[n].fault & FAULT_VALID_MASK));
        end
    end
    // shadow of the card enable, taken at the same data-phase edge as the design
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ctrl_ff <= 1'b0;
            en_ff <= 1'b0;
        end else begin
            wr_ctrl_ff <= aph & i_hwrite & (i_haddr[7:0] == ADDR_CARD_CTRL);
            en_ff <= wr_ctrl_ff ? i_hwdata[0] : en_ff;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    irq_off_a: assert property (!en_ff && !$past(en_ff) |-> !o_host_irq)
        else $error("request while card disabled");
    irq_rise_a: assert property ($rose(o_host_irq) |-> $past(en_ff))
        else $error("request rose without enable");
    fault_irq_a: assert property (fault_hit && en_ff && !wr_ctrl_ff |-> ##2 o_host_irq)
        else $error("fault did not raise request");
    irq_hold_a: assert property (o_host_irq && !aph && !$past(aph) |=> o_host_irq)
        else $error("request dropped without access");
    pend_flag_a: assert property (rd_aph && i_haddr[7:0] == ADDR_CARD_PEND
        |=> o_hrdata == {31'h0, $past(o_host_irq)}) else $error("pending flag wrong");
    io_resv_a: assert property (ax_rd && reg_sel == AX_IO_STATUS
        |=> (o_hrdata & ~{16'h0, IO_VALID_MASK}) == 32'h0) else $error("status spare bit set");
    fault_resv_a: assert property (ax_rd && reg_sel == AX_FAULT_CAUSE
        |=> (o_hrdata & ~FAULT_VALID_MASK) == 32'h0) else $error("fault spare bit set");
    type_code_a: assert property (ax_rd && reg_sel == AX_IRQ_TYPE
        |=> o_hrdata[31:2] == 30'h0) else $error("type code too wide");
    cover property (fault_hit && en_ff);
    cover property ($rose(o_host_irq));
    cover property (rd_aph && i_haddr[7:0] == ADDR_CARD_PEND);
endmodule
bind aio_axis_io_status_and_irq aio_irq_checker u_chk (.*);
`default_nettype wire

// *** dv/aio_host_model.sv ***
// host side: ahb-lite master plus the driver's interrupt service
// assumes the slave may stretch any phase with hready
`timescale 1ns/100ps
`default_nettype none
module aio_host_model
    import aio_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    input wire logic i_irq,
    output var logic o_hsel = 1'b0,
    output var logic [31:0] o_haddr = 32'h0,
    output var logic [1:0] o_htrans = 2'h0,
    output var logic o_hwrite = 1'b0,
    output var logic [2:0] o_hsize = 3'h2,
    output var logic [31:0] o_hwdata = 32'h0
);
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge i_sys_clk);
        o_hsel <= 1'b1;
        o_haddr <= {24'h0, a};
        o_htrans <= 2'b10;
        o_hwrite <= w;
        o_hwdata <= ~o_hwdata;
        do @(posedge i_sys_clk); while (i_hready !== 1'b1);
        o_hsel <= 1'b0;
        o_htrans <= 2'b00;
        o_hwdata <= wd;
        do @(posedge i_sys_clk); while (i_hready !== 1'b1);
        rd = i_hrdata;
    endtask
    // service waits for the request, then reads both cause words to release it
    task automatic ack(input int n, input int gap, output logic [31:0] f, output logic [31:0] e);
        while (i_irq !== 1'b1) @(posedge i_sys_clk);
        repeat (gap) @(posedge i_sys_clk);
        xfer(1'b0, AXIS_BASE + 8'(n << AXIS_STRIDE_SHIFT) + 8'h08, 32'h0, f);
        xfer(1'b0, AXIS_BASE + 8'(n << AXIS_STRIDE_SHIFT) + 8'h0c, 32'h0, e);
    endtask
endmodule
`default_nettype wire

// *** dv/test_axis_io_status_and_irq.sv ***
// self-checking bench for the status and interrupt block
// assumes the host model drives the bus; the bench drives pins and cause pulses
`timescale 1ns/100ps
`default_nettype none
module test_axis_io_status_and_irq;
    import aio_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    aio_pins_type [NUM_AXES-1:0] pins = '0;
    aio_cause_type [NUM_AXES-1:0] cause = '0;
    wire logic hsel, hwrite, hready, hresp, irq;
    wire logic [31:0] haddr, hwdata, hrdata;
    wire logic [1:0] htrans;
    wire logic [2:0] hsize;
    int err_total = 0;
    int samples_checked = 0;
    logic [31:0] tmp, f, e;
    always #2.5 clk = ~clk;
    aio_axis_io_status_and_irq dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp), .i_pins(pins), .i_cause(cause), .o_host_irq(irq));
    aio_host_model host (.i_sys_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .i_irq(irq),
        .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
        .o_hsize(hsize), .o_hwdata(hwdata));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] ax(input int n, input logic [2:0] r);
        return AXIS_BASE + 8'(n << AXIS_STRIDE_SHIFT) + {3'h0, r, 2'h0};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, tmp);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, tmp);
        chk(tmp, exp);
    endtask
    task automatic pulse(input int n, input aio_cause_type c);
        @(posedge clk);
        cause[n] <= c;
        @(posedge clk);
        cause[n] <= '0;
    endtask
    task automatic t_status;
        @(posedge clk);
        pins <= 60'h5a3ce71f0c96b2d;
        rdc(ax(0, 3'h7), 32'h0);
        for (int n = 0; n < NUM_AXES; n++) begin
            rdc(ax(n, AX_POLARITY), {16'h0, RST_POLARITY});
            rdc(ax(n, AX_IO_STATUS), {17'h0, ~pins[n]} & {16'h0, IO_VALID_MASK});
            wr(ax(n, AX_POLARITY), 32'h0000ffff);
            rdc(ax(n, AX_IO_STATUS), {17'h0, pins[n]} & {16'h0, IO_VALID_MASK});
        end
        $display("status test done");
    endtask
    task automatic t_fault;
        pulse(2, '{32'hffffffff, 32'h0, 1'b0, 1'b0});
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_CARD_CTRL, 32'h1);
        rdc(ax(2, AX_FACTOR_MASK), RST_FACTOR_MASK);
        chk({31'h0, irq}, 32'h1);
        rdc(ADDR_CARD_PEND, 32'h1);
        rdc(ax(2, AX_IRQ_TYPE), {30'h0, IRQ_TYPE_FAULT});
        host.ack(2, 0, f, e);
        chk(f, FAULT_VALID_MASK);
        chk(e, 32'h0);
        rdc(ax(2, AX_FAULT_CAUSE), 32'h0);
        rdc(ADDR_CARD_PEND, 32'h0);
        $display("fault test done");
    endtask
    task automatic t_event;
        pulse(1, '{32'h0, 32'h7fffffff, 1'b0, 1'b0});
        rdc(ax(1, AX_IRQ_TYPE), {30'h0, IRQ_TYPE_NONE});
        chk({31'h0, irq}, 32'h0);
        wr(ax(1, AX_FACTOR_MASK), 32'hffffffff);
        rdc(ax(1, AX_FACTOR_MASK), FACTOR_VALID_MASK);
        chk({31'h0, irq}, 32'h1);
        rdc(ax(1, AX_IRQ_TYPE), {30'h0, IRQ_TYPE_EVENT});
        pulse(1, '{32'h1, 32'h0, 1'b0, 1'b0});
        rdc(ax(1, AX_IRQ_TYPE), {30'h0, IRQ_TYPE_BOTH});
        host.ack(1, 3, f, e);
        chk(e, EVENT_VALID_MASK & 32'h7fffffff);
        chk(f, 32'h1);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("event test done");
    endtask
    task automatic t_stop;
        logic [1:0] ctl [4] = '{2'h1, 2'h1, 2'h3, 2'h0};
        for (int i = 0; i < 4; i++) begin
            wr(ax(0, AX_STOP_CTRL), {30'h0, ctl[i]});
            pulse(0, '{32'h0, 32'h0, i != 0, 1'b0});
            pulse(0, '{32'h0, 32'h0, 1'b0, 1'b1});
            repeat (2) @(posedge clk);
            chk({31'h0, irq}, {31'h0, i == 1});
            rdc(ax(0, AX_EVENT_CAUSE), (i == 1) ? 32'h80000000 : 32'h0);
        end
        $display("axis stop test done");
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_status();
        t_fault();
        t_event();
        t_stop();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
